// [common/rsc_pkg.sv]
package rsc_pkg;

    // Clock rate and pulse filter times.
    localparam int          CLK_MHZ       = 100;
    localparam int          T_PIN_MIN_NS  = 2500;
    localparam int          T_BOD_MIN_NS  = 2000;
    localparam int          PIN_CYC       = (T_PIN_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int          BOD_CYC       = (T_BOD_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0]  PIN_FILT_CYC  = 8'(PIN_CYC);
    localparam logic [7:0]  BOD_FILT_CYC  = 8'(BOD_CYC);
    localparam logic [7:0]  FILT_ZERO     = 8'h00;
    localparam logic [7:0]  FILT_ONE      = 8'h01;

    // Register map.
    localparam logic [7:0]  ADDR_RCCS     = 8'h34;
    localparam logic [7:0]  RCCS_RESET    = 8'h00;
    localparam logic [7:0]  RD_IDLE       = 8'h00;
    localparam int          NUM_FLAGS     = 5;
    localparam int          BIT_POR       = 0;
    localparam int          BIT_PIN       = 1;
    localparam int          BIT_BOD       = 2;
    localparam int          BIT_WDT       = 3;
    localparam int          BIT_TAP       = 4;
    localparam int          BIT_TPD       = 7;

    // Brown-out level fuse codes.
    localparam logic [2:0]  BOD_LVL_OFF   = 3'h7;
    localparam logic [2:0]  BOD_LVL_MIN   = 3'h3;

    // Delay selection field inside the clock select fuses.
    localparam int          TOUT_SEL_HI   = 1;
    localparam int          TOUT_SEL_LO   = 0;
    localparam logic [1:0]  TOUT_SEL_0    = 2'h0;
    localparam logic [1:0]  TOUT_SEL_1    = 2'h1;
    localparam logic [1:0]  TOUT_SEL_2    = 2'h2;
    localparam logic [15:0] TOUT_ONE      = 16'h0001;
    localparam logic [15:0] TOUT_ZERO     = 16'h0000;

    typedef enum logic [2:0] {
        ST_HOLD  = 3'h1,
        ST_DELAY = 3'h2,
        ST_RUN   = 3'h4
    } rsc_state_t;

endpackage

// [src/rsc_reset_source_controller.sv]
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps

// Contract
// - Reset initialises I/O registers, fetch restarts vector.
// - Port pins reset when any source activates.
// - Delay counter stretches reset after sources release.
// - Five reset sources are recognised.
// - Pin low beyond minimum width causes reset.
// - Pin rising starts delay before operation.
// - Supply below detection holds reset immediately.
// - Watchdog expiry gives one-cycle reset pulse.
// - Test-port reset register one holds reset.
// - Enabled brown-out asserts reset, release delayed.
// - Brown-out needs drop longer than minimum width.
// - Level fuse selects threshold, disable, reserved.
// - Test-port reset flag, cleared by power-on, software.
// - Watchdog flag, cleared by power-on or software.
// - Brown-out flag, cleared by power-on or software.
// - Pin flag, cleared by power-on or software.
// - Power-on flag cleared only by software.
// - Disable bit or fuse turns test port off.
// - Debug fuse keeps main clock in deep sleep; code keeps it only while the test port is also enabled.
// - Test data output floats when not shifting.
module rsc_reset_source_controller #(
    parameter logic [15:0] P_TOUT_CYC0 = 16'h0006,
    parameter logic [15:0] P_TOUT_CYC1 = 16'h0100,
    parameter logic [15:0] P_TOUT_CYC2 = 16'h1000,
    parameter logic [15:0] P_TOUT_CYC3 = 16'h4000
) (
    // Clock and reset.
    input  wire logic       i_ref_clk,
    input  wire logic       i_rstn,
    // Register port.
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic       i_wr_stb,
    input  wire logic       i_rd_stb,
    output logic      [7:0] o_rd_data,
    // Reset sources.
    input  wire logic       i_supply_ok,
    input  wire logic       i_reset_pin_n,
    input  wire logic       i_wdt_expire,
    input  wire logic       i_wdt_enable,
    input  wire logic       i_bod_below,
    input  wire logic       i_tap_reset_reg,
    // Fuses.
    input  wire logic [3:0] i_clock_select_fuses,
    input  wire logic [2:0] i_brownout_level_fuses,
    input  wire logic       i_test_port_enable_fuse,
    input  wire logic       i_debug_enable_fuse,
    // Sleep and test port.
    input  wire logic       i_sleep_power_down,
    input  wire logic       i_sleep_power_save,
    input  wire logic       i_tap_shifting,
    input  wire logic       i_tdo_data,
    // Reset outputs.
    output logic            o_internal_reset,
    output logic            o_io_reg_init,
    output logic            o_port_reset,
    output logic            o_fetch_reset_vector,
    // Power and test port outputs.
    output logic            o_main_clock_keep,
    output logic            o_test_port_enable,
    output logic            o_tdo,
    output logic            o_tdo_oe_n
);

    rsc_pkg::rsc_state_t          state_q;
    rsc_pkg::rsc_state_t          state_d;
    logic [15:0]                  dly_cnt_q;
    logic [15:0]                  tout_sel;
    logic [7:0]                   pin_cnt_q;
    logic [7:0]                   bod_cnt_q;
    logic                         pin_act_q;
    logic                         bod_act_q;
    logic                         bod_enable;
    logic                         wdt_pulse_q;
    logic                         por_act;
    logic                         src_any;
    logic [rsc_pkg::NUM_FLAGS-1:0] flag_set;
    logic [rsc_pkg::NUM_FLAGS-1:0] flag_q;
    logic                         tpd_q;
    logic                         wr_hit;
    logic                         rd_hit;
    logic                         tp_en;
    logic [7:0]                   reg_val;

    // Source detection.
    assign por_act    = !i_supply_ok;
    assign bod_enable = (i_brownout_level_fuses != rsc_pkg::BOD_LVL_OFF)
                        && (i_brownout_level_fuses >= rsc_pkg::BOD_LVL_MIN);
    assign src_any    = por_act || pin_act_q || wdt_pulse_q || bod_act_q
                        || i_tap_reset_reg;

    // Pin reset is only taken once the pin has been low for the minimum width.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            pin_cnt_q <= rsc_pkg::FILT_ZERO;
            pin_act_q <= 1'b0;
        end else if (i_reset_pin_n) begin
            pin_cnt_q <= rsc_pkg::FILT_ZERO;
            pin_act_q <= 1'b0;
        end else if (pin_cnt_q != rsc_pkg::PIN_FILT_CYC) begin
            pin_cnt_q <= pin_cnt_q + rsc_pkg::FILT_ONE;
            pin_act_q <= (pin_cnt_q + rsc_pkg::FILT_ONE) == rsc_pkg::PIN_FILT_CYC;
        end
    end

    // Brown-out is taken only when enabled and after the minimum pulse width.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            bod_cnt_q <= rsc_pkg::FILT_ZERO;
            bod_act_q <= 1'b0;
        end else if (!bod_enable || !i_bod_below) begin
            bod_cnt_q <= rsc_pkg::FILT_ZERO;
            bod_act_q <= 1'b0;
        end else if (bod_cnt_q != rsc_pkg::BOD_FILT_CYC) begin
            bod_cnt_q <= bod_cnt_q + rsc_pkg::FILT_ONE;
            bod_act_q <= (bod_cnt_q + rsc_pkg::FILT_ONE) == rsc_pkg::BOD_FILT_CYC;
        end
    end

    // Watchdog expiry becomes a single-cycle reset pulse.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            wdt_pulse_q <= 1'b0;
        end else begin
            wdt_pulse_q <= i_wdt_enable && i_wdt_expire && !wdt_pulse_q;
        end
    end

    // Delay length from the clock select fuses.
    always_comb begin
        case (i_clock_select_fuses[rsc_pkg::TOUT_SEL_HI:rsc_pkg::TOUT_SEL_LO])
            rsc_pkg::TOUT_SEL_0: tout_sel = P_TOUT_CYC0;
            rsc_pkg::TOUT_SEL_1: tout_sel = P_TOUT_CYC1;
            rsc_pkg::TOUT_SEL_2: tout_sel = P_TOUT_CYC2;
            default:             tout_sel = P_TOUT_CYC3;
        endcase
    end

    // Reset sequencer: hold while any source is active, then stretch.
    always_comb begin
        state_d = state_q;
        case (state_q)
            rsc_pkg::ST_HOLD: begin
                if (!src_any) begin
                    state_d = rsc_pkg::ST_DELAY;
                end
            end
            rsc_pkg::ST_DELAY: begin
                if (src_any) begin
                    state_d = rsc_pkg::ST_HOLD;
                end else if (dly_cnt_q == rsc_pkg::TOUT_ZERO) begin
                    state_d = rsc_pkg::ST_RUN;
                end
            end
            rsc_pkg::ST_RUN: begin
                if (src_any) begin
                    state_d = rsc_pkg::ST_HOLD;
                end
            end
            default: state_d = rsc_pkg::ST_HOLD;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            state_q <= rsc_pkg::ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // Delay counter is reloaded while held and counts down while stretching.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            dly_cnt_q <= rsc_pkg::TOUT_ZERO;
        end else if (state_q != rsc_pkg::ST_DELAY) begin
            dly_cnt_q <= tout_sel - rsc_pkg::TOUT_ONE;
        end else if (dly_cnt_q != rsc_pkg::TOUT_ZERO) begin
            dly_cnt_q <= dly_cnt_q - rsc_pkg::TOUT_ONE;
        end
    end

    // Reset outputs.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_internal_reset     <= 1'b1;
            o_io_reg_init        <= 1'b1;
            o_port_reset         <= 1'b1;
            o_fetch_reset_vector <= 1'b0;
        end else begin
            o_internal_reset     <= state_d != rsc_pkg::ST_RUN;
            o_io_reg_init        <= state_d != rsc_pkg::ST_RUN;
            o_port_reset         <= src_any;
            o_fetch_reset_vector <= (state_q == rsc_pkg::ST_DELAY)
                                    && (state_d == rsc_pkg::ST_RUN);
        end
    end

    // Register access.
    assign wr_hit = i_wr_stb && (i_addr == rsc_pkg::ADDR_RCCS);
    assign rd_hit = i_rd_stb && (i_addr == rsc_pkg::ADDR_RCCS);

    always_comb begin
        reg_val                           = rsc_pkg::RCCS_RESET;
        reg_val[rsc_pkg::NUM_FLAGS-1:0]   = flag_q;
        reg_val[rsc_pkg::BIT_TPD]         = tpd_q;
    end

    always_comb begin
        flag_set                  = '0;
        flag_set[rsc_pkg::BIT_POR] = por_act;
        flag_set[rsc_pkg::BIT_PIN] = pin_act_q;
        flag_set[rsc_pkg::BIT_BOD] = bod_act_q;
        flag_set[rsc_pkg::BIT_WDT] = wdt_pulse_q;
        flag_set[rsc_pkg::BIT_TAP] = i_tap_reset_reg;
    end

    // Each flag is set on its own source; a set beats any clear in the same cycle.
    for (genvar gi = 0; gi < rsc_pkg::NUM_FLAGS; gi++) begin : g_flag
        always_ff @(posedge i_ref_clk) begin
            if (!i_rstn) begin
                flag_q[gi] <= 1'b0;
            end else if (flag_set[gi]) begin
                flag_q[gi] <= 1'b1;
            end else if (wr_hit && !i_wr_data[gi]) begin
                flag_q[gi] <= 1'b0;
            end else if ((gi != rsc_pkg::BIT_POR) && por_act) begin
                flag_q[gi] <= 1'b0;
            end
        end
    end

    // Test port disable bit is an ordinary I/O bit, cleared during internal reset.
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn || (state_q != rsc_pkg::ST_RUN)) begin
            tpd_q <= 1'b0;
        end else if (wr_hit) begin
            tpd_q <= i_wr_data[rsc_pkg::BIT_TPD];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rd_data <= rsc_pkg::RD_IDLE;
        end else if (rd_hit) begin
            o_rd_data <= reg_val;
        end else begin
            o_rd_data <= rsc_pkg::RD_IDLE;
        end
    end

    // Test port and clock keeping.
    assign tp_en = i_test_port_enable_fuse && !tpd_q;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_test_port_enable <= 1'b0;
            o_main_clock_keep  <= 1'b0;
            o_tdo              <= 1'b0;
            o_tdo_oe_n         <= 1'b1;
        end else begin
            o_test_port_enable <= tp_en;
            o_main_clock_keep  <= i_debug_enable_fuse && tp_en
                                  && (i_sleep_power_down || i_sleep_power_save);
            o_tdo              <= i_tdo_data;
            o_tdo_oe_n         <= !(tp_en && i_tap_shifting);
        end
    end

    // Checks.
    a_src_holds_reset: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        src_any |=> (o_internal_reset && o_port_reset)
    ) else $error("Active source did not assert reset.");

    a_delay_release: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (state_q == rsc_pkg::ST_DELAY && dly_cnt_q == rsc_pkg::TOUT_ZERO && !src_any)
        |=> (o_fetch_reset_vector && !o_internal_reset)
    ) else $error("Delay expiry did not release reset.");

    a_hold_to_delay: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (state_q == rsc_pkg::ST_HOLD && !src_any)
        |=> (state_q == rsc_pkg::ST_DELAY && dly_cnt_q == $past(tout_sel) - rsc_pkg::TOUT_ONE)
    ) else $error("Delay counter not started on release.");

    a_pin_filter: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        pin_act_q |-> (pin_cnt_q == rsc_pkg::PIN_FILT_CYC && $past(!i_reset_pin_n))
    ) else $error("Pin reset taken before minimum width.");

    a_bod_filter: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        $rose(bod_act_q) |-> ($past(bod_cnt_q) == rsc_pkg::BOD_FILT_CYC - rsc_pkg::FILT_ONE)
    ) else $error("Brown-out taken before minimum width.");

    a_bod_disabled: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (i_brownout_level_fuses == rsc_pkg::BOD_LVL_OFF) |=> !bod_act_q
    ) else $error("Disabled brown-out detector caused reset.");

    a_wdt_one_cycle: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        wdt_pulse_q |=> !wdt_pulse_q ##0 flag_q[rsc_pkg::BIT_WDT]
    ) else $error("Watchdog pulse not one cycle or flag not set.");

    a_wdt_delay_start: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        ($fell(wdt_pulse_q) && !src_any) |=> state_q == rsc_pkg::ST_DELAY
    ) else $error("Delay not started on watchdog pulse fall.");

    a_por_flag_keep: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        $fell(flag_q[rsc_pkg::BIT_POR]) |-> $past(wr_hit && !i_wr_data[rsc_pkg::BIT_POR])
    ) else $error("Power-on flag cleared without software write.");

    a_tdo_float: assert property (
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (tp_en && !i_tap_shifting) |=> o_tdo_oe_n
    ) else $error("Test data output driven while not shifting.");

endmodule // rsc_reset_source_controller

// [testbench/reset_source_controller_test.sv]
`timescale 1ns/100ps

module reset_source_controller_test;
    logic        i_ref_clk = 1'b0, i_rstn = 1'b0;
    logic [7:0]  addr = 8'h00, wdat = 8'h00, o_rd_data;
    logic        wr = 1'b0, rd = 1'b0, go = 1'b0, wdt_en = 1'b0;
    logic [2:0]  kind = 3'h0, bod_lvl = 3'h7;
    logic [15:0] len = 16'h0000;
    logic [3:0]  sel = 4'h0;
    logic        tp_fuse = 1'b0, dbg = 1'b0, pd = 1'b0, ps = 1'b0, shift = 1'b0, tdo_d = 1'b0;
    logic        sup_ok, pin_n, wdt_exp, bod_bel, tap_reg;
    logic        o_internal_reset, o_io_reg_init, o_port_reset, o_fetch_reset_vector;
    logic        o_main_clock_keep, o_test_port_enable, o_tdo, o_tdo_oe_n;
    logic        pr_q = 1'b0, ir_q = 1'b0;
    int          pr_cnt = 0, ir_cnt = 0, pr_len = 0, ir_len = 0;
    int          bad_count = 0, n_checks = 0, seed = 32'h7b18;

    rsc_reset_source_controller #(.P_TOUT_CYC0(16'h0004), .P_TOUT_CYC1(16'h0005),
        .P_TOUT_CYC2(16'h0006), .P_TOUT_CYC3(16'h0007)) dut (
        .i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(addr), .i_wr_data(wdat),
        .i_wr_stb(wr), .i_rd_stb(rd), .o_rd_data(o_rd_data), .i_supply_ok(sup_ok),
        .i_reset_pin_n(pin_n), .i_wdt_expire(wdt_exp), .i_wdt_enable(wdt_en),
        .i_bod_below(bod_bel), .i_tap_reset_reg(tap_reg), .i_clock_select_fuses(sel),
        .i_brownout_level_fuses(bod_lvl), .i_test_port_enable_fuse(tp_fuse),
        .i_debug_enable_fuse(dbg), .i_sleep_power_down(pd), .i_sleep_power_save(ps),
        .i_tap_shifting(shift), .i_tdo_data(tdo_d), .o_internal_reset(o_internal_reset),
        .o_io_reg_init(o_io_reg_init), .o_port_reset(o_port_reset),
        .o_fetch_reset_vector(o_fetch_reset_vector), .o_main_clock_keep(o_main_clock_keep),
        .o_test_port_enable(o_test_port_enable), .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n));

    rsc_far_side_model far (.i_ref_clk(i_ref_clk), .i_go(go), .i_kind(kind), .i_len(len),
        .o_supply_ok(sup_ok), .o_reset_pin_n(pin_n), .o_wdt_expire(wdt_exp),
        .o_bod_below(bod_bel), .o_tap_reset_reg(tap_reg));

    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge i_ref_clk) begin
        pr_q   <= o_port_reset;
        ir_q   <= o_internal_reset;
        pr_cnt <= (o_port_reset === 1'b1) ? pr_cnt + 1 : 0;
        ir_cnt <= (o_internal_reset === 1'b1) ? ir_cnt + 1 : 0;
        if (pr_q && o_port_reset === 1'b0)
            pr_len <= pr_cnt;
        if (ir_q && o_internal_reset === 1'b0) begin
            ir_len <= ir_cnt;
            check("fetch on release", o_fetch_reset_vector, 1'b1);
        end
        check("io init", o_io_reg_init, o_internal_reset);
        if (i_rstn)
            check("fetch pulse", o_fetch_reset_vector, ir_q && o_internal_reset === 1'b0);
    end

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_ref_clk);
        addr <= a;
        wdat <= d;
        wr   <= 1'b1;
        @(posedge i_ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge i_ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge i_ref_clk);
        rd <= 1'b0;
        @(posedge i_ref_clk);
        v = o_rd_data;
    endtask

    task automatic launch(input logic [2:0] k, input logic [15:0] n);
        @(posedge i_ref_clk);
        sel  <= {2'b00, 2'($random(seed))};
        kind <= k;
        len  <= n;
        go   <= 1'b1;
        @(posedge i_ref_clk);
        go <= 1'b0;
    endtask

    task automatic fire(input logic [2:0] k, input logic [15:0] n, input int epr,
                        input logic [7:0] eflag);
        logic [7:0] v;
        int         i;
        launch(k, n);
        for (i = 0; i < 400 && o_internal_reset !== 1'b1; i++) @(posedge i_ref_clk);
        check("reset taken", o_internal_reset, 1'b1);
        for (i = 0; i < 2000 && o_internal_reset !== 1'b0; i++) @(posedge i_ref_clk);
        check("reset released", o_internal_reset, 1'b0);
        @(posedge i_ref_clk);
        if (epr > 0)
            check("port reset cycles", 16'(pr_len), 16'(epr));
        check("stretch", 16'(ir_len), 16'(pr_len + 4 + sel[1:0]));
        rd_reg(rsc_pkg::ADDR_RCCS, v);
        check("cause flags", 16'(v), 16'(eflag));
    endtask

    task automatic quiet(input logic [2:0] k, input logic [15:0] n);
        logic hit = 1'b0;
        launch(k, n);
        repeat (n + 4) begin
            @(posedge i_ref_clk);
            hit = hit | (o_port_reset !== 1'b0);
        end
        check("filtered source", hit, 1'b0);
    endtask

    initial begin
        #400000;
        bad_count++;
        conclude();
    end

    initial begin
        logic [7:0]  v;
        logic [15:0] r;
        logic        en;
        int          j;
        repeat (5) @(posedge i_ref_clk);
        check("reset hold", o_internal_reset, 1'b1);
        check("fetch in reset", o_fetch_reset_vector, 1'b0);
        check("tdo off in reset", o_tdo_oe_n, 1'b1);
        i_rstn <= 1'b1;
        for (j = 0; j < 100 && o_internal_reset !== 1'b0; j++) @(posedge i_ref_clk);
        rd_reg(rsc_pkg::ADDR_RCCS, v);
        check("reset value", v, rsc_pkg::RCCS_RESET);
        r = 16'(1 + $unsigned($random(seed)) % 16);
        fire(3'h0, r, r, 8'h01);
        quiet(3'h1, 16'd249);
        fire(3'h1, 16'd300, 0, 8'h03);
        quiet(3'h2, 16'd1);
        wdt_en <= 1'b1;
        fire(3'h2, 16'd1, 1, 8'h0B);
        r = 16'(1 + $unsigned($random(seed)) % 16);
        fire(3'h4, r, r, 8'h1B);
        bod_lvl <= 3'h7;
        quiet(3'h3, 16'd300);
        bod_lvl <= 3'h2;
        quiet(3'h3, 16'd300);
        bod_lvl <= {1'b0, 2'($random(seed))} + 3'h3;
        quiet(3'h3, 16'd150);
        fire(3'h3, 16'd260, 0, 8'h1F);
        wr_reg(8'h35, 8'h00);
        rd_reg(8'h35, v);
        check("unmapped read", v, 8'h00);
        rd_reg(rsc_pkg::ADDR_RCCS, v);
        check("unmapped write", v, 8'h1F);
        wr_reg(rsc_pkg::ADDR_RCCS, 8'h01);
        rd_reg(rsc_pkg::ADDR_RCCS, v);
        check("software clear", v, 8'h01);
        fire(3'h2, 16'd1, 1, 8'h09);
        r = 16'(1 + $unsigned($random(seed)) % 16);
        fire(3'h0, r, r, 8'h01);
        wr_reg(rsc_pkg::ADDR_RCCS, 8'h00);
        rd_reg(rsc_pkg::ADDR_RCCS, v);
        check("power-on flag clear", v, 8'h00);
        for (j = 0; j < 8; j++) begin
            @(posedge i_ref_clk);
            tp_fuse <= j[0];
            shift   <= j[2];
            dbg     <= 1'($random(seed));
            pd      <= 1'($random(seed));
            ps      <= 1'($random(seed));
            tdo_d   <= 1'($random(seed));
            wr_reg(rsc_pkg::ADDR_RCCS, {j[1], 7'h00});
            repeat (3) @(posedge i_ref_clk);
            en = j[0] & !j[1];
            check("test port enable", o_test_port_enable, en);
            check("tdo drive", o_tdo_oe_n, !(en & j[2]));
            check("clock keep", o_main_clock_keep, dbg & en & (pd | ps));
            check("tdo data", o_tdo, tdo_d);
            rd_reg(rsc_pkg::ADDR_RCCS, v);
            check("disable bit", v[7], j[1]);
        end
        conclude();
    end
endmodule // reset_source_controller_test

// [testbench/rsc_far_side_model.sv]
`timescale 1ns/100ps

// Drives one reset source active for a requested number of cycles.
module rsc_far_side_model (
    // Bench control.
    input  wire logic        i_ref_clk,
    input  wire logic        i_go,
    input  wire logic [2:0]  i_kind,
    input  wire logic [15:0] i_len,
    // Reset sources.
    output logic             o_supply_ok,
    output logic             o_reset_pin_n,
    output logic             o_wdt_expire,
    output logic             o_bod_below,
    output logic             o_tap_reset_reg
);
    logic [15:0] cnt_q  = 16'h0000;
    logic [2:0]  kind_q = 3'h0;
    logic        act;

    always_ff @(posedge i_ref_clk) begin
        if (i_go) begin
            cnt_q  <= i_len;
            kind_q <= i_kind;
        end else if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end
    assign act             = cnt_q != 16'h0000;
    assign o_supply_ok     = !(act && kind_q == 3'h0);
    assign o_reset_pin_n   = !(act && kind_q == 3'h1);
    assign o_wdt_expire    = act && kind_q == 3'h2;
    assign o_bod_below     = act && kind_q == 3'h3;
    assign o_tap_reset_reg = act && kind_q == 3'h4;
endmodule // rsc_far_side_model
